/* File: core/rtcnv_pkg.sv */
// Constants, types and the byte map of the clock and memory unit.
// Assumes a single 10 MHz clock and a one-second tick from the oscillator.
package rtcnv_pkg;
    localparam int          ADDR_W    = 13;
    localparam int          MEM_BYTES = 8192;
    localparam logic [12:0] WDOG_ADDR = 13'h1ff7;
    localparam logic [12:0] CTRL_ADDR = 13'h1ff8;
    localparam logic [12:0] SEC_ADDR  = 13'h1ff9;
    localparam logic [12:0] MIN_ADDR  = 13'h1ffa;
    localparam logic [12:0] HOUR_ADDR = 13'h1ffb;
    localparam logic [12:0] DOW_ADDR  = 13'h1ffc;
    localparam logic [12:0] DATE_ADDR = 13'h1ffd;
    localparam logic [12:0] MON_ADDR  = 13'h1ffe;
    localparam logic [12:0] YEAR_ADDR = 13'h1fff;
    localparam int          STOP_BIT  = 7;
    localparam logic [7:0]  ZERO_BCD  = 8'h00;
    localparam logic [7:0]  ONE_BCD   = 8'h01;
    localparam logic [7:0]  MAX_SEC   = 8'h59;
    localparam logic [7:0]  MAX_HOUR  = 8'h23;
    localparam logic [7:0]  MAX_DOW   = 8'h07;
    localparam logic [7:0]  MAX_MON   = 8'h12;
    localparam logic [7:0]  MAX_YEAR  = 8'h99;
    localparam logic [7:0]  FEB_BCD   = 8'h02;
    localparam logic [7:0]  DAYS_28   = 8'h28;
    localparam logic [7:0]  DAYS_29   = 8'h29;
    localparam logic [7:0]  DAYS_30   = 8'h30;
    localparam logic [7:0]  DAYS_31   = 8'h31;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } rtcnv_size_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_XFER = 1'b1
    } rtcnv_fsm_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        rtcnv_size_t size;
        logic [12:0] addr;
        logic [31:0] wdata;
    } rtcnv_req_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] dow;
        logic [7:0] date;
        logic [7:0] mon;
        logic [7:0] year;
    } rtcnv_time_t;
endpackage

/* File: core/rtcnv_bcd_inc.sv */
// One BCD counter field: next value and wrap flag for a bounded count.
// Assumes the value is valid BCD; values at or above the top wrap.
`timescale 1ns/100ps
module rtcnv_bcd_inc (
    input  wire logic [7:0] value,
    input  wire logic [7:0] low,
    input  wire logic [7:0] high,
    output logic      [7:0] next,
    output logic            wrap
);
    always_comb begin
        wrap = (value >= high);
        if (wrap) begin
            next = low;
        end else if (value[3:0] >= 4'h9) begin
            next = {value[7:4] + 4'h1, 4'h0};
        end else begin
            next = {value[7:4], value[3:0] + 4'h1};
        end
    end
endmodule

/* File: core/rtcnv_top.sv */
// Byte-wide battery-backed memory, BCD calendar clock and watchdog
// behind a simple request port fed by the ISA side.
// Assumes one_sec_tick is a one-cycle pulse once a second, synchronous.
`timescale 1ns/100ps
module rtcnv_top (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire rtcnv_pkg::rtcnv_req_t req,
    output logic                      req_ready,
    output logic                      resp_valid,
    output logic               [31:0] resp_rdata,
    input  wire logic                 power_fail,
    input  wire logic                 one_sec_tick,
    output logic                      power_save_command,
    output logic                      wdog_expired
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        rtcnv_pkg::rtcnv_fsm_t  fsm;
        logic [1:0]             idx;
        logic [1:0]             last;
        logic                   write;
        logic [12:0]            addr;
        logic [31:0]            wdata;
        logic [31:0]            rdata;
        logic                   resp;
        rtcnv_pkg::rtcnv_time_t tm;
        logic                   stop;
        logic [7:0]             wd_load;
        logic [7:0]             wd_cnt;
        logic                   wd_exp;
    } rtcnv_state_t;

    rtcnv_state_t state_reg;
    rtcnv_state_t state_next;

    // Battery-backed contents are not cleared by reset.
    logic [7:0]  mem [rtcnv_pkg::MEM_BYTES];
    logic        mem_we;
    logic [12:0] mem_wa;
    logic [7:0]  mem_wd;

    ////////////////////////////////////////////////////////////////////
    rtcnv_pkg::rtcnv_time_t tm;
    rtcnv_pkg::rtcnv_time_t inc;
    logic [6:0]             wr;
    logic [7:0]             month_days;
    logic                   leap;

    assign tm = state_reg.tm;

    // Years 00..99 stand for 2000..2099, so every fourth year is leap.
    always_comb begin
        leap = state_reg.tm.year[4] ? (tm.year[3:0] == 4'h2 ||
                                       tm.year[3:0] == 4'h6)
                                    : (tm.year[3:0] == 4'h0 ||
                                       tm.year[3:0] == 4'h4 ||
                                       tm.year[3:0] == 4'h8);
        unique case (tm.mon)
            rtcnv_pkg::FEB_BCD: begin
                month_days = leap ? rtcnv_pkg::DAYS_29
                                  : rtcnv_pkg::DAYS_28;
            end
            8'h04, 8'h06, 8'h09, 8'h11: begin
                month_days = rtcnv_pkg::DAYS_30;
            end
            default: begin
                month_days = rtcnv_pkg::DAYS_31;
            end
        endcase
    end

    rtcnv_bcd_inc u_sec (
        .value (tm.sec),
        .low   (rtcnv_pkg::ZERO_BCD),
        .high  (rtcnv_pkg::MAX_SEC),
        .next  (inc.sec),
        .wrap  (wr[0])
    );
    rtcnv_bcd_inc u_min (
        .value (tm.min),
        .low   (rtcnv_pkg::ZERO_BCD),
        .high  (rtcnv_pkg::MAX_SEC),
        .next  (inc.min),
        .wrap  (wr[1])
    );
    rtcnv_bcd_inc u_hour (
        .value (tm.hour),
        .low   (rtcnv_pkg::ZERO_BCD),
        .high  (rtcnv_pkg::MAX_HOUR),
        .next  (inc.hour),
        .wrap  (wr[2])
    );
    rtcnv_bcd_inc u_dow (
        .value (tm.dow),
        .low   (rtcnv_pkg::ONE_BCD),
        .high  (rtcnv_pkg::MAX_DOW),
        .next  (inc.dow),
        .wrap  (wr[3])
    );
    rtcnv_bcd_inc u_date (
        .value (tm.date),
        .low   (rtcnv_pkg::ONE_BCD),
        .high  (month_days),
        .next  (inc.date),
        .wrap  (wr[4])
    );
    rtcnv_bcd_inc u_mon (
        .value (tm.mon),
        .low   (rtcnv_pkg::ONE_BCD),
        .high  (rtcnv_pkg::MAX_MON),
        .next  (inc.mon),
        .wrap  (wr[5])
    );
    rtcnv_bcd_inc u_year (
        .value (tm.year),
        .low   (rtcnv_pkg::ZERO_BCD),
        .high  (rtcnv_pkg::MAX_YEAR),
        .next  (inc.year),
        .wrap  (wr[6])
    );

    ////////////////////////////////////////////////////////////////////
    logic [12:0] byte_addr;
    logic [7:0]  byte_rd;
    logic [7:0]  byte_wd;
    logic        byte_wr;
    logic        clk_wr;
    logic        run_tick;

    always_comb begin
        byte_addr = state_reg.addr + {11'h000, state_reg.idx};
        byte_wd   = state_reg.wdata[{state_reg.idx, 3'b000} +: 8];
        unique case (byte_addr)
            rtcnv_pkg::WDOG_ADDR: byte_rd = state_reg.wd_load;
            rtcnv_pkg::CTRL_ADDR: byte_rd = {state_reg.stop, 7'h00};
            rtcnv_pkg::SEC_ADDR:  byte_rd = tm.sec;
            rtcnv_pkg::MIN_ADDR:  byte_rd = tm.min;
            rtcnv_pkg::HOUR_ADDR: byte_rd = tm.hour;
            rtcnv_pkg::DOW_ADDR:  byte_rd = tm.dow;
            rtcnv_pkg::DATE_ADDR: byte_rd = tm.date;
            rtcnv_pkg::MON_ADDR:  byte_rd = tm.mon;
            rtcnv_pkg::YEAR_ADDR: byte_rd = tm.year;
            default:              byte_rd = mem[byte_addr];
        endcase
        byte_wr = (state_reg.fsm == rtcnv_pkg::ST_XFER) && state_reg.write
                  && !power_fail;
        clk_wr  = byte_wr && (byte_addr >= rtcnv_pkg::WDOG_ADDR);
        mem_we  = byte_wr && !clk_wr;
        mem_wa  = byte_addr;
        mem_wd  = byte_wd;
        // A clock write in the tick cycle wins; the tick is skipped.
        run_tick = one_sec_tick && !state_reg.stop && !clk_wr;
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next      = state_reg;
        state_next.resp = 1'b0;

        unique case (state_reg.fsm)
            rtcnv_pkg::ST_IDLE: begin
                if (req.valid) begin
                    state_next.fsm   = rtcnv_pkg::ST_XFER;
                    state_next.idx   = 2'b00;
                    state_next.write = req.write;
                    state_next.addr  = req.addr;
                    state_next.wdata = req.wdata;
                    state_next.rdata = 32'h0000_0000;
                    unique case (req.size)
                        rtcnv_pkg::SZ_HALF: state_next.last = 2'b01;
                        rtcnv_pkg::SZ_WORD: state_next.last = 2'b11;
                        default:            state_next.last = 2'b00;
                    endcase
                end
            end
            rtcnv_pkg::ST_XFER: begin
                state_next.rdata[{state_reg.idx, 3'b000} +: 8] = byte_rd;
                state_next.idx = state_reg.idx + 2'b01;
                if (state_reg.idx == state_reg.last) begin
                    state_next.fsm  = rtcnv_pkg::ST_IDLE;
                    state_next.resp = 1'b1;
                end
            end
        endcase

        if (run_tick) begin
            state_next.tm.sec = inc.sec;
            if (wr[0]) begin
                state_next.tm.min = inc.min;
            end
            if (wr[0] && wr[1]) begin
                state_next.tm.hour = inc.hour;
            end
            if (wr[0] && wr[1] && wr[2]) begin
                state_next.tm.dow  = inc.dow;
                state_next.tm.date = inc.date;
            end
            if (wr[0] && wr[1] && wr[2] && wr[4]) begin
                state_next.tm.mon = inc.mon;
            end
            if (wr[0] && wr[1] && wr[2] && wr[4] && wr[5]) begin
                state_next.tm.year = inc.year;
            end
            if (state_reg.wd_cnt != 8'h00) begin
                state_next.wd_cnt = state_reg.wd_cnt - 8'h01;
                if (state_reg.wd_cnt == 8'h01) begin
                    state_next.wd_exp = 1'b1;
                end
            end
        end

        if (clk_wr) begin
            unique case (byte_addr)
                rtcnv_pkg::WDOG_ADDR: begin
                    state_next.wd_load = byte_wd;
                    state_next.wd_cnt  = byte_wd;
                    state_next.wd_exp  = 1'b0;
                end
                rtcnv_pkg::CTRL_ADDR: begin
                    state_next.stop = byte_wd[rtcnv_pkg::STOP_BIT];
                end
                rtcnv_pkg::SEC_ADDR:  state_next.tm.sec  = byte_wd;
                rtcnv_pkg::MIN_ADDR:  state_next.tm.min  = byte_wd;
                rtcnv_pkg::HOUR_ADDR: state_next.tm.hour = byte_wd;
                rtcnv_pkg::DOW_ADDR:  state_next.tm.dow  = byte_wd;
                rtcnv_pkg::DATE_ADDR: state_next.tm.date = byte_wd;
                rtcnv_pkg::MON_ADDR:  state_next.tm.mon  = byte_wd;
                default:              state_next.tm.year = byte_wd;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg         <= '0;
            state_reg.fsm     <= rtcnv_pkg::ST_IDLE;
            state_reg.tm.dow  <= rtcnv_pkg::ONE_BCD;
            state_reg.tm.date <= rtcnv_pkg::ONE_BCD;
            state_reg.tm.mon  <= rtcnv_pkg::ONE_BCD;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // No interrupt output exists; the time is only visible by reads.
    assign req_ready          = (state_reg.fsm == rtcnv_pkg::ST_IDLE);
    assign resp_valid         = state_reg.resp;
    assign resp_rdata         = state_reg.rdata;
    assign power_save_command = state_reg.stop;
    assign wdog_expired       = state_reg.wd_exp;
endmodule

/* File: test/rtcnv_props.sv */
// Checker for the request port and clock side of the unit.
// Assumes it is bound to rtcnv_top and sees only its ports.
`timescale 1ns/100ps
module rtcnv_props (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  ce,
    input wire rtcnv_pkg::rtcnv_req_t req,
    input wire logic                  req_ready,
    input wire logic                  resp_valid,
    input wire logic           [31:0] resp_rdata,
    input wire logic                  power_fail,
    input wire logic                  one_sec_tick,
    input wire logic                  power_save_command,
    input wire logic                  wdog_expired
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
logic tk;
assign tk = ce && req.valid && req_ready;
////////////////////////////////////////////////////////////////////////////
property p_byte;
    tk && req.size == rtcnv_pkg::SZ_BYTE |=> !req_ready ##1 resp_valid;
endproperty
a_byte: assert property (p_byte) else $error("byte cycle length");
property p_half;
    tk && req.size == rtcnv_pkg::SZ_HALF |=> (!req_ready)[*2] ##1 resp_valid;
endproperty
a_half: assert property (p_half) else $error("half cycle length");
property p_word;
    tk && req.size == rtcnv_pkg::SZ_WORD
        |=> (!req_ready)[*4] ##1 (resp_valid && req_ready);
endproperty
a_word: assert property (p_word) else $error("word cycle length");
property p_pulse;
    resp_valid |=> !resp_valid;
endproperty
a_pulse: assert property (p_pulse) else $error("long response");
property p_cause;
    resp_valid |-> req_ready && $past(!req_ready);
endproperty
a_cause: assert property (p_cause) else $error("stray response");
property p_hold;
    req_ready && !$past(tk) && !resp_valid |-> $stable(resp_rdata);
endproperty
a_hold: assert property (p_hold) else $error("read data moved");
property p_stop;
    $changed(power_save_command) |-> $past(ce && !req_ready && !power_fail);
endproperty
a_stop: assert property (p_stop) else $error("stop bit moved");
property p_wdog;
    $rose(wdog_expired) |-> $past(one_sec_tick && !power_save_command);
endproperty
a_wdog: assert property (p_wdog) else $error("watchdog untimed");
endmodule
////////////////////////////////////////////////////////////////////////////
bind rtcnv_top rtcnv_props u_props (.clk, .rst_n, .ce, .req, .req_ready,
    .resp_valid, .resp_rdata, .power_fail, .one_sec_tick,
    .power_save_command, .wdog_expired);

/* File: test/rtcnv_isa_host.sv */
// Bus master behind the bridge: issues one request at a time.
// Assumes the request port contract of rtcnv_top.
`timescale 1ns/100ps
module rtcnv_isa_host (
    input  wire logic                  clk,
    output rtcnv_pkg::rtcnv_req_t      req,
    input  wire logic                  req_ready,
    input  wire logic                  resp_valid,
    input  wire logic           [31:0] resp_rdata
);
initial req = '0;
////////////////////////////////////////////////////////////////////////////
// Released write, address and data fields show inverted values so a stale sample is caught; the size is kept.
task automatic xfer(input logic w, input rtcnv_pkg::rtcnv_size_t sz,
    input logic [12:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 'x;
    @(posedge clk);
    req <= '{1'b1, w, sz, a, d};
    @(negedge clk);
    while (!req_ready && n < 20) begin
        n++;
        @(negedge clk);
    end
    @(posedge clk);
    req <= '{1'b0, ~w, sz, ~a, ~d};
    n = 0;
    @(negedge clk);
    while (!resp_valid && n < 20) begin
        n++;
        @(negedge clk);
    end
    if (resp_valid) begin
        q = resp_rdata;
        ok = 1'b1;
    end
endtask
endmodule

/* File: test/rtc_nvram_isa_slave_bench.sv */
// Self-checking bench for rtcnv_top with a bus master model.
// Assumes rtcnv_isa_host and the bound checker are compiled first.
`timescale 1ns/100ps
module rtc_nvram_isa_slave_bench;
logic clk, rst_n, ce, power_fail, one_sec_tick;
logic req_ready, resp_valid, power_save_command, wdog_expired;
logic [31:0] resp_rdata;
rtcnv_pkg::rtcnv_req_t req;
int n_fail, num_checks;
logic [31:0] dw [4] = '{32'h00022803, 32'h01022807, 32'h01043003,
                        32'h99123106};
logic [31:0] ex [4] = '{32'h00022904, 32'h01030101, 32'h01050104,
                        32'h00010107};
rtcnv_top u_dut (.clk, .rst_n, .ce, .req, .req_ready, .resp_valid,
    .resp_rdata, .power_fail, .one_sec_tick, .power_save_command,
    .wdog_expired);
rtcnv_isa_host u_host (.clk, .req, .req_ready, .resp_valid, .resp_rdata);
initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////
task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
        n_fail++;
        $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
endtask
task automatic wr(rtcnv_pkg::rtcnv_size_t sz, logic [12:0] a, logic [31:0] d);
    logic [31:0] q;
    logic ok;
    u_host.xfer(1'b1, sz, a, d, q, ok);
    cmp({31'h0, ok}, 32'h1);
endtask
task automatic rd(rtcnv_pkg::rtcnv_size_t sz, logic [12:0] a, logic [31:0] e);
    logic [31:0] q;
    logic ok;
    u_host.xfer(1'b0, sz, a, 32'h0, q, ok);
    cmp(q, e);
endtask
task automatic tick;
    @(posedge clk) one_sec_tick <= 1'b1;
    @(posedge clk) one_sec_tick <= 1'b0;
    @(negedge clk);
endtask
////////////////////////////////////////////////////////////////////////////
task automatic t_mem;
    wr(rtcnv_pkg::SZ_WORD, 13'h0100, 32'h44332211);
    for (int i = 0; i < 4; i++) begin
        rd(rtcnv_pkg::SZ_BYTE, 13'h0100 + 13'(i), 32'(8'h11 * (i + 1)));
    end
    rd(rtcnv_pkg::SZ_HALF, 13'h0101, 32'h00003322);
    rd(rtcnv_pkg::SZ_WORD, 13'h0100, 32'h44332211);
    $display("t_mem done");
endtask
task automatic t_pfail;
    @(posedge clk) power_fail <= 1'b1;
    wr(rtcnv_pkg::SZ_BYTE, 13'h0100, 32'h000000aa);
    wr(rtcnv_pkg::SZ_BYTE, rtcnv_pkg::CTRL_ADDR, 32'h00000080);
    @(posedge clk) power_fail <= 1'b0;
    rd(rtcnv_pkg::SZ_BYTE, 13'h0100, 32'h00000011);
    cmp({31'h0, power_save_command}, 32'h0);
    $display("t_pfail done");
endtask
task automatic t_cal;
    for (int i = 0; i < 4; i++) begin
        wr(rtcnv_pkg::SZ_WORD, rtcnv_pkg::DOW_ADDR, dw[i]);
        wr(rtcnv_pkg::SZ_WORD, rtcnv_pkg::CTRL_ADDR, 32'h23595900);
        tick();
        rd(rtcnv_pkg::SZ_WORD, rtcnv_pkg::CTRL_ADDR, 32'h0);
        rd(rtcnv_pkg::SZ_WORD, rtcnv_pkg::DOW_ADDR, ex[i]);
    end
    $display("t_cal done");
endtask
task automatic t_stop;
    wr(rtcnv_pkg::SZ_BYTE, rtcnv_pkg::WDOG_ADDR, 32'h1);
    tick();
    cmp({31'h0, wdog_expired}, 32'h1);
    wr(rtcnv_pkg::SZ_BYTE, rtcnv_pkg::CTRL_ADDR, 32'h80);
    cmp({31'h0, power_save_command}, 32'h1);
    wr(rtcnv_pkg::SZ_BYTE, rtcnv_pkg::SEC_ADDR, 32'h10);
    tick();
    rd(rtcnv_pkg::SZ_BYTE, rtcnv_pkg::SEC_ADDR, 32'h10);
    wr(rtcnv_pkg::SZ_HALF, rtcnv_pkg::CTRL_ADDR, 32'h1000);
    cmp({31'h0, power_save_command}, 32'h0);
    tick();
    rd(rtcnv_pkg::SZ_BYTE, rtcnv_pkg::SEC_ADDR, 32'h11);
    wr(rtcnv_pkg::SZ_BYTE, rtcnv_pkg::WDOG_ADDR, 32'h2);
    cmp({31'h0, wdog_expired}, 32'h0);
    $display("t_stop done");
endtask
////////////////////////////////////////////////////////////////////////////
task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask
initial begin
    n_fail = 0;
    num_checks = 0;
    ce = 1'b1;
    rst_n = 1'b0;
    power_fail = 1'b0;
    one_sec_tick = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_mem();
    t_pfail();
    t_cal();
    t_stop();
    close_out();
end
// The run needs a few hundred cycles; this cuts a hang short.
initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    close_out();
end
endmodule
